// *** tcd_consts.svh ***
// opcode patterns, field positions and sizes for the decode and flow unit
// assumes a 16-bit instruction word and an 8-bit program counter
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
`define TCD_PC_W 8
`define TCD_STACK_DEPTH 15
`define TCD_PTR_W 4
`define TCD_PC_RESET 8'h00
`define TCD_IRQ_VECTOR 8'hFF
`define TCD_OP_JUMP 8'h81
`define TCD_OP_CALL 8'h83
`define TCD_OP_RETURN 16'h8080
`define TCD_OP_IRET_EN 16'h80F0
`define TCD_OP_IRET_DIS 16'h80D0
`define TCD_OP_INT_EN 16'h8030
`define TCD_OP_INT_DIS 16'h8010
`define TCD_COND_JUMP 3'h1
`define TCD_COND_CALL 3'h3
`define TCD_COND_RET_LO 8'h80
`define TCD_NIB_SHIFT 4'hD
`define TCD_NIB_REGREG 4'hC
`define TCD_NIB_IN_DIR 4'hA
`define TCD_NIB_IN_IND 4'hB
`define TCD_NIB_OUT_DIR 4'hE
`define TCD_NIB_OUT_IND 4'hF
`define TCD_NIB_COND 4'h9
`define TCD_NIB_FLOW 4'h8
`define TCD_SH_R0 8'h0E
`define TCD_SH_R1 8'h0F
`define TCD_SH_RX 8'h0A
`define TCD_SH_RC 8'h08
`define TCD_SH_RR 8'h0C
`define TCD_SH_L0 8'h06
`define TCD_SH_L1 8'h07
`define TCD_SH_LX 8'h04
`define TCD_SH_LC 8'h00
`define TCD_SH_RL 8'h02
`endif

// *** tcd_pkg.sv ***
// types shared by the decode and flow unit and its return stack
package tcd_pkg;
   typedef enum logic [3:0] {
      ALU_LOAD, ALU_AND, ALU_OR, ALU_XOR, ALU_ADD, ALU_ADD_WITH_CARRY_IN,
      ALU_SUB, ALU_SUBTRACT_WITH_BORROW,
      SH_SHIFT_RIGHT_ZERO_FILL, SH_SHIFT_RIGHT_ONE_FILL, SH_SHIFT_RIGHT_SIGN_EXTEND,
      SH_SHIFT_RIGHT_THROUGH_CARRY, SH_ROTATE_RIGHT, SH_SHIFT_LEFT_ZERO_FILL,
      SH_SHIFT_LEFT_ONE_FILL, SH_SHIFT_LEFT_REPEAT_LOW_BIT
   } tcd_op_type;
   typedef enum logic [2:0] {
      CLS_NONE, CLS_ALU_CONST, CLS_ALU_REG, CLS_SHIFT, CLS_PORT_IN, CLS_PORT_OUT
   } tcd_class_type;
   typedef enum {ST_FETCH, ST_EXEC} tcd_state_type;
   // decoded datapath request, one per instruction
   typedef struct packed {
      tcd_class_type cls;
      tcd_op_type op;
      logic shift_left_through_carry;
      logic rotate_left;
      logic [3:0] first_operand_register;
      logic [3:0] second_operand_register;
      logic [7:0] constant;
      logic port_indirect;
   } tcd_dec_type;
   typedef struct packed {
      logic zero;
      logic carry;
   } tcd_flags_type;
endpackage

// *** tcd_stack.sv ***
// cyclic return-address stack of flip-flops
// assumes push and pop are never requested in the same cycle
`timescale 1ns/10ps
`include "tcd_consts.svh"
module tcd_stack
   import tcd_pkg::*;
#(
   parameter int DEPTH = `TCD_STACK_DEPTH,
   parameter int PC_W = `TCD_PC_W
) (
   // clock
   input wire logic I_MCLK,
   // requests
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [PC_W-1:0] i_data,
   // newest entry
   output logic [PC_W-1:0] o_top
);
   logic [PC_W-1:0] mem [DEPTH];
   // start point only keeps the pointer known; any power-up value from 0 to 14 would serve as well
   logic [`TCD_PTR_W-1:0] ptr = '0;
   logic [`TCD_PTR_W-1:0] next_ptr;
   logic [`TCD_PTR_W-1:0] prev_ptr;

   // pointer wraps over the entries, so overflow overwrites the oldest
   assign next_ptr = (ptr == `TCD_PTR_W'(DEPTH - 1)) ? '0 : ptr + 1'b1;
   assign prev_ptr = (ptr == '0) ? `TCD_PTR_W'(DEPTH - 1) : ptr - 1'b1;
   assign o_top = mem[prev_ptr]; // underflow simply reads what is there

   // no reset on purpose: any start point within the fifteen entries is as good as another
   always_ff @(posedge I_MCLK) begin
      if (i_push) begin
         mem[ptr] <= i_data;
         ptr <= next_ptr;
      end else if (i_pop) begin
         ptr <= prev_ptr;
      end
   end
endmodule

// *** tcd_core.sv ***
// opcode decoder and program-flow unit: pc, return stack, interrupt enable
// assumes a combinational program rom answering within one cycle on o_ROM_ADDR
// and an external alu that owns the flags and reports them on i_FLAGS
// Notes on behaviour
// - eight-bit pc over 256 words, steps by one unless flow is redirected
// - sequential step from FF wraps to 00
// - 81aa jumps unconditionally to the low byte address
// - 91,95,99,9D jumps taken on zero set, zero clear, carry set, carry clear
// - jump, call and return never alter zero or carry
// - taken call pushes current pc and loads target; 83 unconditional, 93..9F tested
// - return stack holds fifteen pc values
// - stack is cyclic, a full push overwrites the oldest entry
// - stack pointer needs no reset, nothing else touches the stack
// - taken return pops newest entry and resumes at it plus one; 8080 unconditional
// - conditional returns 9080,9480,9880,9C80 test the same four conditions
// - returns beyond calls keep reading whatever the pointer reaches
// - interrupt return always pops into pc without increment
// - interrupt return restores the flags saved at interrupt entry
// - 80F0 returns and enables interrupts, 80D0 returns and disables them
// - 8030 enables, 8010 disables interrupts, flow otherwise sequential
// - interrupt entry point is the last location, FF
// - top nibble D is shift or rotate, low byte picks the variant
// - top nibbles 0 to 7 are register-with-constant alu operations
// - top nibble C is register-with-register, low three bits pick the operation
// - Axpp reads port pp, Bxy0 reads port held in second register
// - Expp writes port pp, Fxy0 writes port held in second register
// - every instruction takes exactly two clocks
// - accepted interrupt calls FF, saves flags and clears the enable
// - interrupt enable is clear after reset
`timescale 1ns/10ps
`include "tcd_consts.svh"
module tcd_core
   import tcd_pkg::*;
#(
   parameter int PC_W = `TCD_PC_W,
   parameter int STACK_DEPTH = `TCD_STACK_DEPTH
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // program rom
   output logic [PC_W-1:0] O_ROM_ADDR,
   input wire logic [15:0] I_ROM_DATA,
   // flags from the alu and restore path back to it
   input wire tcd_flags_type I_FLAGS,
   output logic O_FLAGS_RESTORE,
   output tcd_flags_type O_FLAGS_SAVED,
   // interrupt pin
   input wire logic I_IRQ,
   // decoded instruction to the datapath
   output logic O_DEC_VALID,
   output tcd_dec_type O_DEC,
   // status
   output logic O_INT_ENABLE,
   output logic [PC_W-1:0] O_PC
);
   tcd_state_type state;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic int_enable;
   logic next_int_enable;
   tcd_flags_type saved_flags;
   logic [15:0] instr;
   logic irq_meta;
   logic irq_sync;
   logic restore;
   tcd_dec_type dec;
   logic dec_valid;

   // opcode fields
   wire [3:0] top_nib = instr[15:12];
   wire [3:0] cond_nib = instr[11:8];
   wire [7:0] low_byte = instr[7:0];
   wire is_cond = (top_nib == `TCD_NIB_COND);
   wire is_flow = (top_nib == `TCD_NIB_FLOW);

   // condition code in bits 11:10: zero set, zero clear, carry set, carry clear
   function automatic logic cond_met(input logic [1:0] code, input tcd_flags_type f);
      case (code)
         2'h0: cond_met = f.zero;
         2'h1: cond_met = !f.zero;
         2'h2: cond_met = f.carry;
         default: cond_met = !f.carry;
      endcase
   endfunction

   // test outcome for the conditional forms, true for unconditional ones
   wire test_ok = is_cond ? cond_met(cond_nib[3:2], I_FLAGS) : 1'b1;
   wire flow_or_cond = is_flow || is_cond;
   wire kind_nib_ok = is_flow ? (cond_nib[3:2] == 2'h0) : 1'b1;
   wire is_jump = flow_or_cond && kind_nib_ok
                  && (cond_nib[1:0] == 2'h1) && (instr[15:8] != 8'h83);
   wire is_call = flow_or_cond && kind_nib_ok
                  && (cond_nib[1:0] == 2'h3);
   wire is_ret = flow_or_cond && kind_nib_ok
                 && (cond_nib[1:0] == 2'h0) && (low_byte == `TCD_COND_RET_LO);
   wire is_iret_en = (instr == `TCD_OP_IRET_EN);
   wire is_iret_dis = (instr == `TCD_OP_IRET_DIS);
   wire is_iret = is_iret_en || is_iret_dis;
   wire is_int_en = (instr == `TCD_OP_INT_EN);
   wire is_int_dis = (instr == `TCD_OP_INT_DIS);

   // interrupt accepted only at an instruction boundary while enabled
   wire take_irq = (state == ST_EXEC) && irq_sync && int_enable;
   wire exec = (state == ST_EXEC) && !take_irq;

   wire do_jump = exec && is_jump && test_ok;
   wire do_call = exec && is_call && test_ok;
   wire do_ret = exec && is_ret && test_ok;
   wire do_iret = exec && is_iret;

   // stack traffic: interrupt pushes the pc of the instruction it pre-empts
   wire push = do_call || take_irq;
   wire pop = do_ret || do_iret;
   wire [PC_W-1:0] stack_top;

   tcd_stack #(
      .DEPTH(STACK_DEPTH),
      .PC_W(PC_W)
   ) u_stack (
      .I_MCLK(I_MCLK),
      .i_push(push),
      .i_pop(pop),
      .i_data(pc),
      .o_top(stack_top)
   );

   // next program counter; sequential step wraps naturally at FF
   always_comb begin
      next_pc = pc;
      if (take_irq) begin
         next_pc = `TCD_IRQ_VECTOR;
      end else if (exec) begin
         if (do_jump || do_call) begin
            next_pc = low_byte;
         end else if (do_ret) begin
            next_pc = stack_top + 1'b1;
         end else if (do_iret) begin
            next_pc = stack_top;
         end else begin
            next_pc = pc + 1'b1;
         end
      end
   end

   // interrupt enable updates
   always_comb begin
      next_int_enable = int_enable;
      if (take_irq) begin
         next_int_enable = 1'b0;
      end else if (exec && (is_iret_en || is_int_en)) begin
         next_int_enable = 1'b1;
      end else if (exec && (is_iret_dis || is_int_dis)) begin
         next_int_enable = 1'b0;
      end
   end

   // datapath decode; flow instructions raise no datapath request, flags kept
   always_comb begin
      dec = '0;
      dec_valid = 1'b0;
      dec.first_operand_register = cond_nib;
      dec.second_operand_register = low_byte[7:4];
      dec.constant = low_byte;
      if (!top_nib[3]) begin
         dec.cls = CLS_ALU_CONST;
         dec.op = tcd_op_type'({1'b0, top_nib[2:0]});
         dec_valid = 1'b1;
      end else if (top_nib == `TCD_NIB_REGREG) begin
         dec.cls = CLS_ALU_REG;
         dec.op = tcd_op_type'({1'b0, instr[2:0]});
         dec_valid = 1'b1;
      end else if (top_nib == `TCD_NIB_SHIFT) begin
         dec.cls = CLS_SHIFT;
         dec_valid = 1'b1;
         case (low_byte)
            `TCD_SH_R0: dec.op = SH_SHIFT_RIGHT_ZERO_FILL;
            `TCD_SH_R1: dec.op = SH_SHIFT_RIGHT_ONE_FILL;
            `TCD_SH_RX: dec.op = SH_SHIFT_RIGHT_SIGN_EXTEND;
            `TCD_SH_RC: dec.op = SH_SHIFT_RIGHT_THROUGH_CARRY;
            `TCD_SH_RR: dec.op = SH_ROTATE_RIGHT;
            `TCD_SH_L0: dec.op = SH_SHIFT_LEFT_ZERO_FILL;
            `TCD_SH_L1: dec.op = SH_SHIFT_LEFT_ONE_FILL;
            `TCD_SH_LX: dec.op = SH_SHIFT_LEFT_REPEAT_LOW_BIT;
            `TCD_SH_LC: dec.shift_left_through_carry = 1'b1;
            `TCD_SH_RL: dec.rotate_left = 1'b1;
            default: dec_valid = 1'b0; // undefined shift codes do nothing
         endcase
      end else if (top_nib == `TCD_NIB_IN_DIR || top_nib == `TCD_NIB_IN_IND) begin
         dec.cls = CLS_PORT_IN;
         dec.port_indirect = top_nib[0];
         dec_valid = 1'b1;
      end else if (top_nib == `TCD_NIB_OUT_DIR || top_nib == `TCD_NIB_OUT_IND) begin
         dec.cls = CLS_PORT_OUT;
         dec.port_indirect = top_nib[0];
         dec_valid = 1'b1;
      end
   end

   assign restore = do_iret;

   // two-state sequencer: fetch then execute, every instruction two clocks
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         state <= ST_FETCH;
      end else begin
         case (state)
            ST_FETCH: state <= ST_EXEC;
            ST_EXEC: state <= ST_FETCH;
            default: state <= ST_FETCH;
         endcase
      end
   end

   // pc, enable and instruction latch
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         pc <= `TCD_PC_RESET;
         int_enable <= 1'b0;
         instr <= 16'h0000;
      end else begin
         pc <= next_pc;
         int_enable <= next_int_enable;
         if (state == ST_FETCH) begin
            instr <= I_ROM_DATA;
         end
      end
   end

   // flags captured on interrupt entry for the return path
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         saved_flags <= '0;
      end else if (take_irq) begin
         saved_flags <= I_FLAGS;
      end
   end

   // interrupt pin is asynchronous to the core clock
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         irq_meta <= 1'b0;
         irq_sync <= 1'b0;
      end else begin
         irq_meta <= I_IRQ;
         irq_sync <= irq_meta;
      end
   end

   // registered outputs, valid one cycle per executed datapath instruction
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_DEC_VALID <= 1'b0;
         O_DEC <= '0;
         O_FLAGS_RESTORE <= 1'b0;
      end else begin
         O_DEC_VALID <= exec && dec_valid;
         O_DEC <= dec;
         O_FLAGS_RESTORE <= restore;
      end
   end

   assign O_ROM_ADDR = pc;
   assign O_PC = pc;
   assign O_INT_ENABLE = int_enable;
   assign O_FLAGS_SAVED = saved_flags;
endmodule

// *** tcd_core_monitor.sv ***
// concurrent checks on the ports of the decode and flow unit
// assumes the rom answers combinationally, so its word stands as long as the address
`timescale 1ns/10ps
`include "tcd_consts.svh"
module tcd_core_monitor
   import tcd_pkg::*;
#(
   parameter int PC_W = `TCD_PC_W
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // rom side
   input wire logic [PC_W-1:0] O_ROM_ADDR,
   input wire logic [15:0] I_ROM_DATA,
   // watched outputs
   input wire logic O_FLAGS_RESTORE,
   input wire logic O_DEC_VALID,
   input wire tcd_dec_type O_DEC,
   input wire logic O_INT_ENABLE,
   input wire logic [PC_W-1:0] O_PC
);
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   // a pc update is seen one edge late, beside the word that caused it
   sequence pc_moved;
      $changed(O_PC);
   endsequence
   a_pc_two_cycles: assert property ($changed(O_PC) |=> $stable(O_PC))
      else $error("pc changed in consecutive cycles");
   a_addr_is_pc: assert property (O_ROM_ADDR == O_PC)
      else $error("rom address differs from pc");
   // pc FF is left out: an accepted interrupt lands there too
   a_seq_step: assert property (pc_moved ##0 ($past(I_ROM_DATA[15:13]) != 3'h4 && O_PC != 8'hFF)
      |-> O_PC == 8'($past(O_PC) + 8'h01))
      else $error("sequential pc step wrong");
   a_jump_lands: assert property (pc_moved ##0 $past(I_ROM_DATA[15:8]) == `TCD_OP_JUMP
      |-> (O_PC == $past(I_ROM_DATA[7:0]) || O_PC == 8'hFF))
      else $error("jump target wrong");
   a_flow_no_dec: assert property ($changed(O_PC) && $past(I_ROM_DATA[15:13]) == 3'h4
      |-> !O_DEC_VALID)
      else $error("flow op reached datapath");
   a_const_decode: assert property (pc_moved ##0 (!$past(I_ROM_DATA[15]) && O_PC != 8'hFF)
      |-> O_DEC_VALID && O_DEC.cls == CLS_ALU_CONST && O_DEC.constant == $past(I_ROM_DATA[7:0])
      && O_DEC.first_operand_register == $past(I_ROM_DATA[11:8]))
      else $error("constant op decoded wrong");
   a_valid_pulse: assert property (O_DEC_VALID |=> !O_DEC_VALID)
      else $error("decode valid longer than one cycle");
   a_restore_pulse: assert property (O_FLAGS_RESTORE |=> !O_FLAGS_RESTORE)
      else $error("flag restore longer than one cycle");
   a_enable_set: assert property (pc_moved ##0 ($past(I_ROM_DATA) == `TCD_OP_INT_EN
      && O_PC != 8'hFF) |-> ##[0:1] O_INT_ENABLE)
      else $error("enable not set");
   a_enable_clear: assert property ($fell(O_INT_ENABLE) |-> O_PC == 8'hFF
      || $past(I_ROM_DATA, 1) inside {`TCD_OP_INT_DIS, `TCD_OP_IRET_DIS}
      || $past(I_ROM_DATA, 2) inside {`TCD_OP_INT_DIS, `TCD_OP_IRET_DIS})
      else $error("enable cleared without cause");
   c_restore: cover property (O_FLAGS_RESTORE);
   c_vector: cover property (pc_moved ##0 O_PC == 8'hFF);
   c_wrap: cover property (pc_moved ##0 O_PC == 8'h00);
endmodule
bind tcd_core tcd_core_monitor #(.PC_W(PC_W)) tcd_core_monitor_i (.I_MCLK(I_MCLK),
   .I_RST(I_RST), .O_ROM_ADDR(O_ROM_ADDR), .I_ROM_DATA(I_ROM_DATA),
   .O_FLAGS_RESTORE(O_FLAGS_RESTORE), .O_DEC_VALID(O_DEC_VALID), .O_DEC(O_DEC),
   .O_INT_ENABLE(O_INT_ENABLE), .O_PC(O_PC));

// *** tcd_rom_model.sv ***
// program rom stand-in: 256 words read combinationally from the address
// assumes the bench writes words into mem just after a clock edge
`timescale 1ns/10ps
module tcd_rom_model (
   // fetch address
   input wire logic [7:0] i_addr,
   // instruction word
   output logic [15:0] o_data
);
   logic [15:0] mem [256];
   // unwritten words read as a harmless load of zero rather than unknown
   initial begin
      foreach (mem[i]) begin
         mem[i] = 16'h0000;
      end
   end
   // combinational read keeps the word standing as long as the address does
   assign o_data = mem[i_addr];
endmodule

// *** tb_top.sv ***
// self-checking bench for the decode and flow unit with a rom model
// assumes each word is placed at the pc just after its fetch cycle starts
`timescale 1ns/10ps
module tb_top;
   import tcd_pkg::*;
   typedef struct {logic [15:0] w; logic [1:0] f; logic [7:0] pc; tcd_class_type c;} tcd_row_type;
   logic clk, rst, irq, restore, dec_valid, int_en, en;
   logic [7:0] rom_addr, pc, prev;
   logic [15:0] rom_data;
   tcd_flags_type flags, saved;
   tcd_dec_type dec;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_restore = 0;
   // word, flags (zero,carry), next pc, datapath class
   tcd_row_type rows [31] = '{
      '{16'h0312, 2'h0, 8'h01, CLS_ALU_CONST}, '{16'hD20E, 2'h0, 8'h02, CLS_SHIFT},
      '{16'hC125, 2'h0, 8'h03, CLS_ALU_REG}, '{16'hA356, 2'h0, 8'h04, CLS_PORT_IN},
      '{16'hB120, 2'h0, 8'h05, CLS_PORT_IN}, '{16'hE356, 2'h0, 8'h06, CLS_PORT_OUT},
      '{16'hF120, 2'h0, 8'h07, CLS_PORT_OUT}, '{16'h81F0, 2'h0, 8'hF0, CLS_NONE},
      '{16'h9120, 2'h0, 8'hF1, CLS_NONE}, '{16'h9120, 2'h2, 8'h20, CLS_NONE},
      '{16'h9530, 2'h2, 8'h21, CLS_NONE}, '{16'h9530, 2'h0, 8'h30, CLS_NONE},
      '{16'h9940, 2'h0, 8'h31, CLS_NONE}, '{16'h9940, 2'h1, 8'h40, CLS_NONE},
      '{16'h9D50, 2'h1, 8'h41, CLS_NONE}, '{16'h9D50, 2'h0, 8'h50, CLS_NONE},
      '{16'h8030, 2'h0, 8'h51, CLS_NONE}, '{16'h8010, 2'h0, 8'h52, CLS_NONE},
      '{16'h83A0, 2'h0, 8'hA0, CLS_NONE}, '{16'h9380, 2'h0, 8'hA1, CLS_NONE},
      '{16'h9780, 2'h0, 8'h80, CLS_NONE}, '{16'h9C80, 2'h1, 8'h81, CLS_NONE},
      '{16'h9880, 2'h1, 8'hA2, CLS_NONE}, '{16'h9080, 2'h0, 8'hA3, CLS_NONE},
      '{16'h9480, 2'h0, 8'h53, CLS_NONE}, '{16'h9B10, 2'h1, 8'h10, CLS_NONE},
      '{16'h9F60, 2'h0, 8'h60, CLS_NONE}, '{16'h8080, 2'h0, 8'h11, CLS_NONE},
      '{16'h8080, 2'h0, 8'h54, CLS_NONE}, '{16'h81FF, 2'h0, 8'hFF, CLS_NONE},
      '{16'hC120, 2'h0, 8'h00, CLS_ALU_REG}};
   logic [7:0] shift_codes [10] = '{8'h0E, 8'h0F, 8'h0A, 8'h08, 8'h0C,
      8'h06, 8'h07, 8'h04, 8'h00, 8'h02};
   logic [15:0] iret [2] = '{16'h80D0, 16'h80F0};
   tcd_core tcd_core_i (.I_MCLK(clk), .I_RST(rst), .O_ROM_ADDR(rom_addr),
      .I_ROM_DATA(rom_data), .I_FLAGS(flags), .O_FLAGS_RESTORE(restore),
      .O_FLAGS_SAVED(saved), .I_IRQ(irq), .O_DEC_VALID(dec_valid), .O_DEC(dec),
      .O_INT_ENABLE(int_en), .O_PC(pc));
   tcd_rom_model tcd_rom_model_i (.i_addr(rom_addr), .o_data(rom_data));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // restore pulses counted apart, since they trail the return by a cycle
   always @(posedge clk) begin
      if (restore === 1'b1) n_restore++;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // place one word at the pc and let both of its cycles run
   task automatic exec(input logic [15:0] w);
      tcd_rom_model_i.mem[pc] = w;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // a hung design must still reach the verdict
   initial begin
      #5000000;
      n_mismatch++;
      stop_test();
   end
   // main sequence: table, shift codes, interrupts, reset, stack wrap
   initial begin
      rst = 1'b1;
      irq = 1'b0;
      flags = 2'h0;
      en = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      chk(int_en, 1'b0);
      foreach (rows[i]) begin
         flags = rows[i].f;
         exec(rows[i].w);
         en = (rows[i].w == 16'h8030) ? 1'b1 : (rows[i].w == 16'h8010) ? 1'b0 : en;
         chk(pc, rows[i].pc);
         chk(int_en, en);
         chk(dec_valid ? dec.cls : CLS_NONE, rows[i].c);
      end
      foreach (shift_codes[i]) begin
         exec({8'hD3, shift_codes[i]});
         chk(dec_valid ? dec.cls : CLS_NONE, CLS_SHIFT);
         chk({dec.first_operand_register, dec.shift_left_through_carry, dec.rotate_left},
            {4'h3, shift_codes[i] == 8'h00, shift_codes[i] == 8'h02});
      end
      foreach (iret[k]) begin
         flags = 2'h0;
         exec(16'h8030);
         flags = 2'h3;
         irq = 1'b1;
         for (int t = 0; t < 12 && pc !== 8'hFF; t++) begin
            prev = pc;
            exec(16'h0000);
         end
         chk(pc, 8'hFF);
         if (pc !== 8'hFF) stop_test();
         chk(int_en, 1'b0);
         chk(saved, 2'h3);
         irq = 1'b0;
         flags = 2'h0;
         exec(iret[k]);
         chk(pc, prev);
         chk(int_en, iret[k] == 16'h80F0);
      end
      // the second restore pulse is only counted at the edge after the return
      @(posedge clk);
      #1;
      chk(16'(n_restore), 16'h0002);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({pc, int_en, dec_valid}, 10'h000);
      rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         exec({8'h83, 8'(i + 1)});
      end
      chk(pc, 8'h10);
      for (int i = 15; i > 0; i--) begin
         exec(16'h8080);
         chk(pc, 8'(i + 1));
      end
      stop_test();
   end
endmodule
